// [src/translation_system_control_regs.sv]
// Overview of operation
// - top control is 64 bits, resets 0x30C50838
// - bit 44 gives next bypass-safe state
// - bits 31,30,27,13 enable authentication keys
// - bit 25 selects top-level byte order
// - byte order reset comes from strap input
// - bit 12 enables instruction caches
// - bit 2 enables data caches
// - bit 0 enables top-level translation
// - bit 52 limits range0 top byte
// - bit 51 limits range1 top byte
// - dirty update needs bit 40 and 39
// - bit 39 enables access flag update
// - low translation control unset until written
// - bit 29 limits top byte handling
// - bits 22/21 enable dirty, access updates
// - host extension gives second level low layout
// - third-level control is 32 bits wide
// - identifier in 63:48, source selectable
// - base address above x, table aligned
// - walk ignores low bits, read keeps them
// - bit 0 flags common translation sharing
// - x from size field; upper zero
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
module translation_system_control_regs (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core side
    input wire logic reset_byte_order_input,
    input wire logic exc_taken_top,
    input wire logic [15:0] range1_address_space_identifier,
    output logic store_bypass_safe_state,
    output tsc_pkg::sys_ctrl_t top_ctrl,
    output tsc_pkg::walk_ctrl_t low_walk,
    output tsc_pkg::walk_ctrl_t hyp_walk,
    output tsc_pkg::walk_ctrl_t top_walk
);

    // byte-lane merge of a bus word into a stored word
    function automatic logic [31:0] merge_word(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_word

    // alignment exponent of the first-level table from size and granule
    function automatic logic [5:0] align_exp(input logic [5:0] region_size_field,
                                             input logic [1:0] tg0);
        logic [6:0] ia;
        logic [6:0] gb;
        logic [6:0] st;
        logic [6:0] rem;
        ia = 7'h40 - {1'b0, region_size_field};
        case (tg0)
            2'h1: begin
                gb = 7'h10;
                st = 7'h0D;
            end
            2'h2: begin
                gb = 7'h0E;
                st = 7'h0B;
            end
            default: begin
                gb = 7'h0C;
                st = 7'h09;
            end
        endcase
        rem = (ia > gb) ? (ia - gb) % st : 7'h00;
        if (rem == 7'h00) begin
            rem = st;
        end
        return 6'(rem + 7'h03);
    endfunction : align_exp

    // clear the base bits below x and the sharing bit
    function automatic logic [47:0] eff_base(input logic [63:0] ttb,
                                             input logic [5:0] x);
        logic [47:0] mask;
        mask = ~((48'h1 << x) - 48'h1);
        return ttb[47:0] & mask & ~48'h1;
    endfunction : eff_base

    // storage
    logic [63:0] sctl_q;
    logic [63:0] sctl_d;
    logic [63:0] tcr1_q;
    logic [63:0] tcr1_d;
    logic [63:0] tcr2_q;
    logic [63:0] tcr2_d;
    logic [31:0] tcr3_q;
    logic [31:0] tcr3_d;
    logic [63:0] ttb1_q;
    logic [63:0] ttb1_d;
    logic [63:0] ttb2_q;
    logic [63:0] ttb2_d;
    logic vhe_q;
    logic [4:0] written_q; // tcr1, tcr2, tcr3, ttb1, ttb2
    logic store_bypass_safe_state_q;
    logic [31:0] prdata_q;
    // strap capture
    logic strap_meta_q;
    logic strap_sync_q;
    logic [1:0] strap_cnt_q;
    // registered walker settings
    tsc_pkg::sys_ctrl_t top_ctrl_q;
    tsc_pkg::walk_ctrl_t low_walk_q;
    tsc_pkg::walk_ctrl_t hyp_walk_q;
    tsc_pkg::walk_ctrl_t top_walk_q;
    tsc_pkg::walk_ctrl_t low_walk_d;
    tsc_pkg::walk_ctrl_t hyp_walk_d;
    tsc_pkg::walk_ctrl_t top_walk_d;

    // bus decode
    wire logic setup_ph = psel & ~penable;
    wire logic access_ph = psel & penable;
    wire logic hit = (paddr <= tsc_pkg::OFF_STATUS) && (paddr[1:0] == 2'h0)
        && (paddr != 8'h1C);
    wire logic wr = access_ph & pwrite & hit;
    wire logic [31:0] lo_sctl = merge_word(sctl_q[31:0], pwdata, pstrb);
    wire logic [31:0] hi_sctl = merge_word(sctl_q[63:32], pwdata, pstrb);
    wire logic [31:0] lo_tcr1 = merge_word(tcr1_q[31:0], pwdata, pstrb);
    wire logic [31:0] hi_tcr1 = merge_word(tcr1_q[63:32], pwdata, pstrb);
    wire logic [31:0] lo_tcr2 = merge_word(tcr2_q[31:0], pwdata, pstrb);
    wire logic [31:0] hi_tcr2 = merge_word(tcr2_q[63:32], pwdata, pstrb);
    wire logic [31:0] all_tcr3 = merge_word(tcr3_q, pwdata, pstrb);
    wire logic [31:0] lo_ttb1 = merge_word(ttb1_q[31:0], pwdata, pstrb);
    wire logic [31:0] hi_ttb1 = merge_word(ttb1_q[63:32], pwdata, pstrb);
    wire logic [31:0] lo_ttb2 = merge_word(ttb2_q[31:0], pwdata, pstrb);
    wire logic [31:0] hi_ttb2 = merge_word(ttb2_q[63:32], pwdata, pstrb);
    wire logic [31:0] cfg_word = merge_word({31'h0, vhe_q}, pwdata, pstrb);

    // reserved bits read fixed, only the field positions are stored
    wire logic [63:0] sctl_view = (sctl_q & tsc_pkg::SCTL_WMASK)
        | (tsc_pkg::SCTL_RESET & ~tsc_pkg::SCTL_WMASK);
    // identifier field is reserved zero without the host extension
    wire logic [63:0] ttb2_view = vhe_q ? ttb2_q : {16'h0000, ttb2_q[47:0]};
    wire logic [5:0] x_low = align_exp(tcr1_q[tsc_pkg::TCR_REGION_SIZE_FIELD_LSB +: 6],
                                       tcr1_q[tsc_pkg::TCR_TG0_LSB +: 2]);
    wire logic [5:0] x_hyp = align_exp(tcr2_q[tsc_pkg::TCR_REGION_SIZE_FIELD_LSB +: 6],
                                       tcr2_q[tsc_pkg::TCR_TG0_LSB +: 2]);
    wire logic strap_load = (strap_cnt_q == 2'h1);

    // next values of the stored registers
    always_comb begin
        sctl_d = sctl_q;
        if (wr && paddr == tsc_pkg::OFF_SCTL_LO) sctl_d[31:0] = lo_sctl;
        if (wr && paddr == tsc_pkg::OFF_SCTL_HI) sctl_d[63:32] = hi_sctl;
        sctl_d = sctl_d & tsc_pkg::SCTL_WMASK;
        // strap takes the byte-order bit once after reset
        if (strap_load) sctl_d[tsc_pkg::SCTL_EE] = strap_sync_q;
        tcr1_d = tcr1_q;
        if (wr && paddr == tsc_pkg::OFF_TCR1_LO) tcr1_d[31:0] = lo_tcr1;
        if (wr && paddr == tsc_pkg::OFF_TCR1_HI) tcr1_d[63:32] = hi_tcr1;
        tcr2_d = tcr2_q;
        if (wr && paddr == tsc_pkg::OFF_TCR2_LO) tcr2_d[31:0] = lo_tcr2;
        if (wr && paddr == tsc_pkg::OFF_TCR2_HI) tcr2_d[63:32] = hi_tcr2;
        tcr3_d = tcr3_q;
        if (wr && paddr == tsc_pkg::OFF_TCR3) tcr3_d = all_tcr3;
        // base registers keep every written bit for readback, except ttb2 identifier lanes without the host extension
        ttb1_d = ttb1_q;
        if (wr && paddr == tsc_pkg::OFF_TTB1_LO) ttb1_d[31:0] = lo_ttb1;
        if (wr && paddr == tsc_pkg::OFF_TTB1_HI) ttb1_d[63:32] = hi_ttb1;
        ttb2_d = ttb2_q;
        if (wr && paddr == tsc_pkg::OFF_TTB2_LO) ttb2_d[31:0] = lo_ttb2;
        if (wr && paddr == tsc_pkg::OFF_TTB2_HI) begin
            // identifier lanes ignored while they are reserved
            ttb2_d[63:32] = vhe_q ? hi_ttb2 : {ttb2_q[63:48], hi_ttb2[15:0]};
        end
    end

    // register file flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sctl_q <= tsc_pkg::SCTL_RESET & tsc_pkg::SCTL_WMASK;
            tcr1_q <= 64'h0;
            tcr2_q <= 64'h0;
            tcr3_q <= 32'h0;
            ttb1_q <= 64'h0;
            ttb2_q <= 64'h0;
        end else begin
            sctl_q <= sctl_d;
            tcr1_q <= tcr1_d;
            tcr2_q <= tcr2_d;
            tcr3_q <= tcr3_d;
            ttb1_q <= ttb1_d;
            ttb2_q <= ttb2_d;
        end
    end

    // config bit, written flags and bypass-safe state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            vhe_q <= 1'b0;
            written_q <= 5'h00;
            store_bypass_safe_state_q <= 1'b0;
        end else begin
            if (wr && paddr == tsc_pkg::OFF_CONFIG) vhe_q <= cfg_word[tsc_pkg::CFG_VHE];
            // a control register counts as set once either word is written
            written_q <= written_q | {
                wr && (paddr == tsc_pkg::OFF_TTB2_LO || paddr == tsc_pkg::OFF_TTB2_HI),
                wr && (paddr == tsc_pkg::OFF_TTB1_LO || paddr == tsc_pkg::OFF_TTB1_HI),
                wr && (paddr == tsc_pkg::OFF_TCR3),
                wr && (paddr == tsc_pkg::OFF_TCR2_LO || paddr == tsc_pkg::OFF_TCR2_HI),
                wr && (paddr == tsc_pkg::OFF_TCR1_LO || paddr == tsc_pkg::OFF_TCR1_HI)
            };
            // exception to the top level loads the default state
            if (exc_taken_top) store_bypass_safe_state_q <= sctl_q[tsc_pkg::SCTL_DEFAULT_STORE_BYPASS_SAFE];
        end
    end

    // strap synchroniser and load counter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_meta_q <= 1'b0;
            strap_sync_q <= 1'b0;
            strap_cnt_q <= tsc_pkg::STRAP_WAIT;
        end else begin
            strap_meta_q <= reset_byte_order_input;
            strap_sync_q <= strap_meta_q;
            if (strap_cnt_q != 2'h0) strap_cnt_q <= strap_cnt_q - 2'h1;
        end
    end

    // read mux, sampled in the setup phase
    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            tsc_pkg::OFF_SCTL_LO: rd_mux = sctl_view[31:0];
            tsc_pkg::OFF_SCTL_HI: rd_mux = sctl_view[63:32];
            tsc_pkg::OFF_TCR1_LO: rd_mux = tcr1_q[31:0];
            tsc_pkg::OFF_TCR1_HI: rd_mux = tcr1_q[63:32];
            tsc_pkg::OFF_TCR2_LO: rd_mux = tcr2_q[31:0];
            tsc_pkg::OFF_TCR2_HI: rd_mux = tcr2_q[63:32];
            tsc_pkg::OFF_TCR3: rd_mux = tcr3_q;
            tsc_pkg::OFF_TTB1_LO: rd_mux = ttb1_q[31:0];
            tsc_pkg::OFF_TTB1_HI: rd_mux = ttb1_q[63:32];
            tsc_pkg::OFF_TTB2_LO: rd_mux = ttb2_view[31:0];
            tsc_pkg::OFF_TTB2_HI: rd_mux = ttb2_view[63:32];
            tsc_pkg::OFF_CONFIG: rd_mux = {31'h0, vhe_q};
            tsc_pkg::OFF_STATUS: rd_mux = {7'h0, store_bypass_safe_state_q, 2'h0, x_hyp, 2'h0, x_low,
                                           2'h0, written_q, strap_cnt_q == 2'h0};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_q <= 32'h0;
        end else if (setup_ph) begin
            prdata_q <= rd_mux;
        end
    end

    // walker settings from the stored registers
    always_comb begin
        // lowest level
        low_walk_d.valid = written_q[0] & written_q[3];
        low_walk_d.base = eff_base(ttb1_q, x_low);
        low_walk_d.address_space_identifier = tcr1_q[tsc_pkg::TCR1_A1] ? range1_address_space_identifier
            : ttb1_q[tsc_pkg::TTB_ADDRESS_SPACE_IDENTIFIER_LSB +: 16];
        low_walk_d.common_translation_sharing = ttb1_q[tsc_pkg::TTB_CNP];
        low_walk_d.top_byte_data_only_range0 = tcr1_q[tsc_pkg::TCR1_TOP_BYTE_DATA_ONLY_RANGE0];
        low_walk_d.top_byte_data_only_range1 = tcr1_q[tsc_pkg::TCR1_TOP_BYTE_DATA_ONLY_RANGE1];
        low_walk_d.access_flag_auto_update = tcr1_q[tsc_pkg::TCR1_HA];
        low_walk_d.dirty_state_auto_update = tcr1_q[tsc_pkg::TCR1_HD]
            & tcr1_q[tsc_pkg::TCR1_HA];
        low_walk_d.align_exp = x_low;
        // second level, low layout under the host extension
        hyp_walk_d.valid = written_q[1] & written_q[4];
        hyp_walk_d.base = eff_base(ttb2_q, x_hyp);
        hyp_walk_d.address_space_identifier = ttb2_view[tsc_pkg::TTB_ADDRESS_SPACE_IDENTIFIER_LSB +: 16];
        hyp_walk_d.common_translation_sharing = ttb2_q[tsc_pkg::TTB_CNP];
        if (vhe_q) begin
            hyp_walk_d.top_byte_data_only_range0 = tcr2_q[tsc_pkg::TCR1_TOP_BYTE_DATA_ONLY_RANGE0];
            hyp_walk_d.top_byte_data_only_range1 = tcr2_q[tsc_pkg::TCR1_TOP_BYTE_DATA_ONLY_RANGE1];
            hyp_walk_d.access_flag_auto_update = tcr2_q[tsc_pkg::TCR1_HA];
            hyp_walk_d.dirty_state_auto_update = tcr2_q[tsc_pkg::TCR1_HD]
                & tcr2_q[tsc_pkg::TCR1_HA];
        end else begin
            hyp_walk_d.top_byte_data_only_range0 = tcr2_q[tsc_pkg::TCR_TOP_BYTE_DATA_ONLY];
            hyp_walk_d.top_byte_data_only_range1 = 1'b0;
            hyp_walk_d.access_flag_auto_update = tcr2_q[tsc_pkg::TCR_HA];
            hyp_walk_d.dirty_state_auto_update = tcr2_q[tsc_pkg::TCR_HD];
        end
        hyp_walk_d.align_exp = x_hyp;
        // top level, control only; its base register lives elsewhere
        top_walk_d = '0;
        top_walk_d.valid = written_q[2];
        top_walk_d.top_byte_data_only_range0 = tcr3_q[tsc_pkg::TCR_TOP_BYTE_DATA_ONLY];
        top_walk_d.access_flag_auto_update = tcr3_q[tsc_pkg::TCR_HA];
        top_walk_d.dirty_state_auto_update = tcr3_q[tsc_pkg::TCR_HD];
    end

    // output flops for the walkers and global enables
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            top_ctrl_q <= '0;
            low_walk_q <= '0;
            hyp_walk_q <= '0;
            top_walk_q <= '0;
        end else begin
            top_ctrl_q <= '{sctl_q[tsc_pkg::SCTL_MMU], sctl_q[tsc_pkg::SCTL_DCACHE],
                            sctl_q[tsc_pkg::SCTL_ICACHE], sctl_q[tsc_pkg::SCTL_EE],
                            sctl_q[tsc_pkg::SCTL_INSTR_KEY_A_AUTH_ENABLE], sctl_q[tsc_pkg::SCTL_INSTR_KEY_B_AUTH_ENABLE],
                            sctl_q[tsc_pkg::SCTL_DATA_KEY_A_AUTH_ENABLE], sctl_q[tsc_pkg::SCTL_DATA_KEY_B_AUTH_ENABLE],
                            sctl_q[tsc_pkg::SCTL_DEFAULT_STORE_BYPASS_SAFE]};
            low_walk_q <= low_walk_d;
            hyp_walk_q <= hyp_walk_d;
            top_walk_q <= top_walk_d;
        end
    end

    // outputs
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = access_ph & ~hit;
    assign store_bypass_safe_state = store_bypass_safe_state_q;
    assign top_ctrl = top_ctrl_q;
    assign low_walk = low_walk_q;
    assign hyp_walk = hyp_walk_q;
    assign top_walk = top_walk_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    reserved_bits_a: assert property (sctl_view[29:28] == 2'h3
        && sctl_view[63:45] == 19'h0 && sctl_view[43:32] == 12'h0)
        else $error("reserved control bits not fixed");
    store_bypass_safe_state_load_a: assert property (exc_taken_top |=> store_bypass_safe_state_q == $past(sctl_view[44]))
        else $error("bypass-safe state not loaded on exception");
    strap_load_a: assert property (strap_load |=> top_ctrl_q.big_endian == 1'b0
        ##0 sctl_q[tsc_pkg::SCTL_EE] == $past(strap_sync_q))
        else $error("byte order strap not captured");
    reset_value_a: assert property (strap_cnt_q == 2'h2 |->
        (sctl_view & ~(64'h1 << tsc_pkg::SCTL_EE)) == tsc_pkg::SCTL_RESET)
        else $error("control reset value wrong");
    dirty_gate_a: assert property (low_walk_q.dirty_state_auto_update
        |-> low_walk_q.access_flag_auto_update)
        else $error("dirty update without access flag update");
    base_align_a: assert property ((low_walk_q.base
        & ((48'h1 << low_walk_q.align_exp) - 48'h1)) == 48'h0)
        else $error("walk base not aligned");
    readback_a: assert property (wr && paddr == tsc_pkg::OFF_TTB1_LO && pstrb == 4'hF
        |=> ttb1_q[31:0] == $past(pwdata))
        else $error("base register readback lost");
    address_space_identifier_pick_a: assert property (!tcr1_q[tsc_pkg::TCR1_A1]
        |=> low_walk_q.address_space_identifier == $past(ttb1_q[63:48]))
        else $error("identifier source wrong");
    hyp_res0_a: assert property (!vhe_q |=> hyp_walk_q.address_space_identifier == 16'h0000)
        else $error("reserved identifier leaked");

    sctl_write_c: cover property (wr && paddr == tsc_pkg::OFF_SCTL_LO);
    store_bypass_safe_state_set_c: cover property (exc_taken_top && sctl_q[tsc_pkg::SCTL_DEFAULT_STORE_BYPASS_SAFE]);
    vhe_mode_c: cover property (vhe_q && wr && paddr == tsc_pkg::OFF_TTB2_HI);
    bad_addr_c: cover property (pslverr);

endmodule : translation_system_control_regs

// [shared/tsc_pkg.sv]
package tsc_pkg;

    // register word offsets on the bus (byte addresses, one word each)
    localparam logic [7:0] OFF_SCTL_LO = 8'h00;
    localparam logic [7:0] OFF_SCTL_HI = 8'h04;
    localparam logic [7:0] OFF_TCR1_LO = 8'h08;
    localparam logic [7:0] OFF_TCR1_HI = 8'h0C;
    localparam logic [7:0] OFF_TCR2_LO = 8'h10;
    localparam logic [7:0] OFF_TCR2_HI = 8'h14;
    localparam logic [7:0] OFF_TCR3 = 8'h18;
    localparam logic [7:0] OFF_TTB1_LO = 8'h20;
    localparam logic [7:0] OFF_TTB1_HI = 8'h24;
    localparam logic [7:0] OFF_TTB2_LO = 8'h28;
    localparam logic [7:0] OFF_TTB2_HI = 8'h2C;
    localparam logic [7:0] OFF_CONFIG = 8'h30;
    localparam logic [7:0] OFF_STATUS = 8'h34;

    // top-level system control fields
    localparam int SCTL_DEFAULT_STORE_BYPASS_SAFE = 44;
    localparam int SCTL_INSTR_KEY_A_AUTH_ENABLE = 31;
    localparam int SCTL_INSTR_KEY_B_AUTH_ENABLE = 30;
    localparam int SCTL_DATA_KEY_A_AUTH_ENABLE = 27;
    localparam int SCTL_EE = 25;
    localparam int SCTL_DATA_KEY_B_AUTH_ENABLE = 13;
    localparam int SCTL_ICACHE = 12;
    localparam int SCTL_DCACHE = 2;
    localparam int SCTL_MMU = 0;
    localparam logic [63:0] SCTL_RESET = 64'h0000_0000_30C5_0838;
    // only these positions store software data; all others are fixed
    localparam logic [63:0] SCTL_WMASK = (64'h1 << SCTL_DEFAULT_STORE_BYPASS_SAFE) | (64'h1 << SCTL_INSTR_KEY_A_AUTH_ENABLE)
        | (64'h1 << SCTL_INSTR_KEY_B_AUTH_ENABLE) | (64'h1 << SCTL_DATA_KEY_A_AUTH_ENABLE) | (64'h1 << SCTL_EE)
        | (64'h1 << SCTL_DATA_KEY_B_AUTH_ENABLE) | (64'h1 << SCTL_ICACHE) | (64'h1 << SCTL_DCACHE)
        | (64'h1 << SCTL_MMU);

    // translation control fields, lowest-level layout
    localparam int TCR1_TOP_BYTE_DATA_ONLY_RANGE0 = 52;
    localparam int TCR1_TOP_BYTE_DATA_ONLY_RANGE1 = 51;
    localparam int TCR1_HD = 40;
    localparam int TCR1_HA = 39;
    localparam int TCR1_A1 = 22;
    // fields shared by every layout
    localparam int TCR_REGION_SIZE_FIELD_LSB = 0;
    localparam int TCR_TG0_LSB = 14;
    // translation control fields, upper-level layout
    localparam int TCR_TOP_BYTE_DATA_ONLY = 29;
    localparam int TCR_HD = 22;
    localparam int TCR_HA = 21;

    // table base fields
    localparam int TTB_ADDRESS_SPACE_IDENTIFIER_LSB = 48;
    localparam int TTB_CNP = 0;

    // config and status bits
    localparam int CFG_VHE = 0;
    localparam int STS_STRAP_DONE = 0;
    localparam int STS_WRITTEN_LSB = 1;
    localparam int STS_X1_LSB = 8;
    localparam int STS_X2_LSB = 16;
    localparam int STS_STORE_BYPASS_SAFE_STATE = 24;

    // edges after reset release before the byte-order strap is loaded
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    // global enables of the top level
    typedef struct packed {
        logic mmu_enable;
        logic dcache_enable;
        logic icache_enable;
        logic big_endian;
        logic instr_key_a_auth_enable;
        logic instr_key_b_auth_enable;
        logic data_key_a_auth_enable;
        logic data_key_b_auth_enable;
        logic default_store_bypass_safe;
    } sys_ctrl_t;

    // settings handed to one table walker
    typedef struct packed {
        logic valid;
        logic [47:0] base;
        logic [15:0] address_space_identifier;
        logic common_translation_sharing;
        logic top_byte_data_only_range0;
        logic top_byte_data_only_range1;
        logic access_flag_auto_update;
        logic dirty_state_auto_update;
        logic [5:0] align_exp;
    } walk_ctrl_t;

endpackage : tsc_pkg

// [test/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    // clock, reset and bus drivers
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // core side
    logic reset_byte_order_input = 1'b1;
    logic exc_taken_top = 1'b0;
    logic [15:0] range1_address_space_identifier = 16'h0;
    logic store_bypass_safe_state;
    tsc_pkg::sys_ctrl_t top_ctrl;
    tsc_pkg::walk_ctrl_t low_walk, hyp_walk, top_walk;
    // bookkeeping and scratch values
    int bad_count = 0;
    int checked = 0;
    int xe;
    integer seed = 32'h650B;
    logic [31:0] rd;
    logic err;
    logic cfg;
    logic [63:0] v, t1, tb;
    logic [7:0] bad_addr [3] = '{8'h1C, 8'h38, 8'h02};

    // 25 MHz clock
    always #20 clk = ~clk;

    translation_system_control_regs DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_byte_order_input(reset_byte_order_input), .exc_taken_top(exc_taken_top),
        .range1_address_space_identifier(range1_address_space_identifier), .store_bypass_safe_state(store_bypass_safe_state),
        .top_ctrl(top_ctrl), .low_walk(low_walk), .hyp_walk(hyp_walk), .top_walk(top_walk));

    // compare and count
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, entered right after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so the next call never reassigns psel in this time step
        @(posedge clk);
    endtask : apb

    // 64-bit register as low word then high word
    task automatic wr64(input logic [7:0] a, input logic [63:0] d);
        apb(1'b1, a, d[31:0]);
        apb(1'b1, a + 8'h04, d[63:32]);
    endtask : wr64

    task automatic rd64(input logic [7:0] a, output logic [63:0] d);
        apb(1'b0, a, 32'h0);
        d[31:0] = rd;
        apb(1'b0, a + 8'h04, 32'h0);
        d[63:32] = rd;
    endtask : rd64

    // expected alignment exponent from size and granule fields
    function automatic int x_of(input logic [63:0] t);
        int gb;
        int r;
        gb = (t[15:14] == 2'h1) ? 16 : (t[15:14] == 2'h2) ? 14 : 12;
        r = (64 - int'(t[5:0]) - gb) % (gb - 3);
        if (r == 0) r = gb - 3;
        return r + 3;
    endfunction : x_of

    // reset with a chosen strap, then wait out the strap load
    task automatic do_reset(input logic s);
        sys_rst <= 1'b1;
        reset_byte_order_input <= s;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : do_reset

    // verdict, the only end of the run
    task automatic give_verdict();
        if (bad_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // watchdog against a hung handshake
    initial begin
        #(40 * 20000);
        bad_count++;
        give_verdict();
    end

    // main sequence
    initial begin
        do_reset(1'b1);
        rd64(tsc_pkg::OFF_SCTL_LO, v);
        chk(v, tsc_pkg::SCTL_RESET | (64'h1 << 25));
        repeat (4) begin
            v = {$random(seed), $random(seed)};
            wr64(tsc_pkg::OFF_SCTL_LO, v);
            rd64(tsc_pkg::OFF_SCTL_LO, t1);
            chk(t1, (tsc_pkg::SCTL_RESET & ~tsc_pkg::SCTL_WMASK) | (v & tsc_pkg::SCTL_WMASK));
            chk(top_ctrl, {v[0], v[2], v[12], v[25], v[31], v[30], v[27], v[13], v[44]});
            exc_taken_top <= 1'b1;
            @(posedge clk);
            exc_taken_top <= 1'b0;
            @(posedge clk);
            chk(store_bypass_safe_state, v[44]);
        end
        repeat (6) begin
            t1 = {$random(seed), $random(seed)};
            t1[5:0] = 6'(16 + {$random(seed)} % 24);
            tb = {$random(seed), $random(seed)};
            cfg = $random(seed);
            range1_address_space_identifier <= $random(seed);
            wr64(tsc_pkg::OFF_TCR1_LO, t1);
            wr64(tsc_pkg::OFF_TTB1_LO, tb);
            apb(1'b1, tsc_pkg::OFF_TCR3, t1[31:0]);
            wr64(tsc_pkg::OFF_TCR2_LO, t1);
            rd64(tsc_pkg::OFF_TCR1_LO, v);
            chk(v, t1);
            rd64(tsc_pkg::OFF_TCR2_LO, v);
            chk(v, t1);
            rd64(tsc_pkg::OFF_TTB1_LO, v);
            chk(v, tb);
            xe = x_of(t1);
            chk(low_walk.valid, 1'b1);
            chk(low_walk.base, tb[47:0] & ~((48'h1 << xe) - 48'h1));
            chk(low_walk.align_exp, 6'(xe));
            chk(low_walk.address_space_identifier, t1[22] ? range1_address_space_identifier : tb[63:48]);
            chk(low_walk.common_translation_sharing, tb[0]);
            chk({low_walk.top_byte_data_only_range0, low_walk.top_byte_data_only_range1,
                low_walk.access_flag_auto_update, low_walk.dirty_state_auto_update},
                {t1[52], t1[51], t1[39], t1[40] & t1[39]});
            chk({top_walk.top_byte_data_only_range0, top_walk.access_flag_auto_update,
                top_walk.dirty_state_auto_update}, {t1[29], t1[21], t1[22]});
            apb(1'b1, tsc_pkg::OFF_CONFIG, {31'h0, cfg});
            wr64(tsc_pkg::OFF_TTB2_LO, tb);
            rd64(tsc_pkg::OFF_TTB2_LO, v);
            chk(v, cfg ? tb : {16'h0, tb[47:0]});
            chk({hyp_walk.valid, hyp_walk.address_space_identifier, hyp_walk.common_translation_sharing, hyp_walk.top_byte_data_only_range0,
                hyp_walk.access_flag_auto_update}, cfg ? {1'b1, tb[63:48], tb[0], t1[52], t1[39]}
                : {1'b1, 16'h0, tb[0], t1[29], t1[21]});
        end
        // unmapped and misaligned places refuse
        foreach (bad_addr[i]) begin
            apb(1'b1, bad_addr[i], 32'hFFFF_FFFF);
            apb(1'b0, bad_addr[i], 32'h0);
            chk({err, rd}, {1'b1, 32'h0});
        end
        // second reset with the other strap level
        do_reset(1'b0);
        chk(low_walk.valid, 1'b0);
        rd64(tsc_pkg::OFF_SCTL_LO, v);
        chk(v, tsc_pkg::SCTL_RESET);
        give_verdict();
    end
endmodule : tb_top
